// >>> inc/sgb_regs.svh
`ifndef SGB_REGS_SVH
`define SGB_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SGB_OFS_CFG 8'h00
`define SGB_OFS_WAIT_UP 8'h04
`define SGB_OFS_WAIT_DOWN 8'h08
`define SGB_OFS_RAMP_UP 8'h0C
`define SGB_OFS_RAMP_DOWN 8'h10
`define SGB_OFS_STATUS 8'h14
`define SGB_OFS_BANK1 8'h20
`define SGB_OFS_BANK2 8'h40
`define SGB_COEF_STRIDE 8'h04

// ****************************************
// fields and codes
// ****************************************
`define SGB_MODE_LSB 0
`define SGB_COND_LSB 4
`define SGB_LOOP_BIT 8
`define SGB_TUNELESS_BIT 12
`define SGB_MODE_AUTO 4'h2
`define SGB_MON_BANK1 2'h1
`define SGB_MON_BANK2 2'h2
`define SGB_STAT_WAIT_BIT 4
`define SGB_STAT_RAMP_BIT 5
`define SGB_STAT_FOLLOW_BIT 8

// ****************************************
// reset values
// ****************************************
`define SGB_CFG_RESET 16'h0000
`define SGB_TIME_RESET 16'h0000
`define SGB_COEF_RESET {16'h0064, 16'h03E8, 16'h01F4, 16'h0064, 16'h0190, 16'h07D0, 16'h0190}

// ****************************************
// timing
// ****************************************
`define SGB_MS_NS 1000000
`define SGB_CLK_NS 5

`endif

// >>> inc/sgb_pkg.sv
package sgb_pkg;

    // ****************************************
    // types
    // ****************************************
    typedef logic [15:0] sgb_word_t;
    typedef logic [6:0][15:0] sgb_coef_t;

    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_RAMP} sgb_phase_t;

    typedef struct packed {
        sgb_phase_t phase;
        logic tgt2;
        logic on2;
        logic follow2;
        logic [1:0] mon;
        logic [31:0] tick;
        logic [15:0] ms;
        sgb_coef_t start;
        sgb_coef_t coef;
        logic rdy;
        logic resp;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic [15:0] cfg;
        logic [15:0] wait_up;
        logic [15:0] wait_down;
        logic [15:0] ramp_up;
        logic [15:0] ramp_down;
        sgb_coef_t b1;
        sgb_coef_t b2;
    } sgb_state_t;

endpackage : sgb_pkg

// >>> logic/sgb_switch.sv
`timescale 1ns/1ps
`include "sgb_regs.svh"

module sgb_switch #(
    parameter int unsigned TICK_CYC = `SGB_MS_NS / `SGB_CLK_NS
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // host select and drive status
    input wire logic bank_sel,
    input wire logic pos_ctrl,
    input wire logic cmd_busy,
    input wire logic motor_stopped,
    input wire logic pos_done,
    input wire logic pos_near,
    input wire logic filter_busy,
    input wire logic ref_pulse,
    // applied coefficients, bank monitor and loop structure select
    output sgb_pkg::sgb_word_t speed_gain,
    output sgb_pkg::sgb_word_t speed_integral,
    output sgb_pkg::sgb_word_t position_gain,
    output sgb_pkg::sgb_word_t force_filter,
    output sgb_pkg::sgb_word_t follow_gain,
    output sgb_pkg::sgb_word_t follow_comp,
    output sgb_pkg::sgb_word_t friction_gain,
    output logic [1:0] active_bank_monitor,
    output logic loop_structure_select
);
    import sgb_pkg::*;

    localparam sgb_state_t RST = '{phase: PH_IDLE, tgt2: 1'b0, on2: 1'b0, follow2: 1'b0,
        mon: `SGB_MON_BANK1, tick: 32'h0, ms: 16'h0, start: `SGB_COEF_RESET, coef: `SGB_COEF_RESET,
        rdy: 1'b1, resp: 1'b0, dp_wr: 1'b0, dp_addr: 8'h00, rdata: 32'h0, cfg: `SGB_CFG_RESET,
        wait_up: `SGB_TIME_RESET, wait_down: `SGB_TIME_RESET, ramp_up: `SGB_TIME_RESET,
        ramp_down: `SGB_TIME_RESET, b1: `SGB_COEF_RESET, b2: `SGB_COEF_RESET};

    sgb_state_t s_q;
    sgb_state_t s_d;
    logic acc;
    logic tuneless;
    logic mode_auto;
    logic manual;
    logic [3:0] cond;
    logic cond_a;
    logic fixed2;
    logic want2;
    logic ramp_en;
    logic [15:0] wlen;
    logic [15:0] rlen;
    logic [15:0] rdiv;
    sgb_coef_t tgt_v;
    sgb_coef_t ramp_v;

    // ****************************************
    // mode and condition decode
    // ****************************************
    assign acc = hsel && htrans[1] && hready;
    assign tuneless = s_q.cfg[`SGB_TUNELESS_BIT];
    assign mode_auto = (s_q.cfg[`SGB_MODE_LSB +: 4] == `SGB_MODE_AUTO) && !tuneless;
    // reserved code falls back to manual
    assign manual = !mode_auto && !tuneless;
    assign cond = s_q.cfg[`SGB_COND_LSB +: 4];

    always_comb begin
        case (cond)
            4'h0: cond_a = pos_done;
            4'h1: cond_a = !pos_done;
            4'h2: cond_a = pos_near;
            4'h3: cond_a = !pos_near;
            4'h4: cond_a = !filter_busy && !ref_pulse;
            4'h5: cond_a = ref_pulse;
            default: cond_a = 1'b0;
        endcase
    end

    assign fixed2 = (cond == 4'h1) || (cond == 4'h3) || (cond == 4'h5);

    always_comb begin
        if (tuneless) begin
            want2 = 1'b0;
        end else if (manual) begin
            want2 = bank_sel;
        end else if (!pos_ctrl) begin
            want2 = fixed2;
        end else begin
            want2 = cond_a;
        end
    end

    assign ramp_en = mode_auto && pos_ctrl;
    assign wlen = s_q.tgt2 ? s_q.wait_up : s_q.wait_down;
    assign rlen = s_q.tgt2 ? s_q.ramp_up : s_q.ramp_down;
    assign rdiv = (rlen == 16'h0) ? 16'h1 : rlen;
    assign tgt_v = s_q.tgt2 ? s_q.b2 : s_q.b1;

    // ****************************************
    // per-coefficient linear interpolation
    // ****************************************
    // a divider per coefficient is costly but keeps every ramp exactly linear
    for (genvar g = 0; g < 7; g++) begin : g_ramp
        logic signed [33:0] diff;
        logic signed [33:0] prod;
        logic signed [33:0] quo;
        assign diff = $signed({18'h0, tgt_v[g]}) - $signed({18'h0, s_q.start[g]});
        assign prod = diff * $signed({18'h0, s_q.ms});
        assign quo = prod / $signed({18'h0, rdiv});
        assign ramp_v[g] = s_q.start[g] + quo[15:0];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0;
        s_d = s_q;
        if (s_q.dp_wr) begin
            case (s_q.dp_addr)
                `SGB_OFS_CFG: s_d.cfg = hwdata[15:0];
                `SGB_OFS_WAIT_UP: s_d.wait_up = hwdata[15:0];
                `SGB_OFS_WAIT_DOWN: s_d.wait_down = hwdata[15:0];
                `SGB_OFS_RAMP_UP: s_d.ramp_up = hwdata[15:0];
                `SGB_OFS_RAMP_DOWN: s_d.ramp_down = hwdata[15:0];
                default: ;
            endcase
            for (int i = 0; i < 7; i++) begin
                if (s_q.dp_addr == `SGB_OFS_BANK1 + 8'(i * 4)) s_d.b1[i] = hwdata[15:0];
                if (s_q.dp_addr == `SGB_OFS_BANK2 + 8'(i * 4)) s_d.b2[i] = hwdata[15:0];
            end
        end
        // follow pair swaps only in manual mode when idle and stopped; other modes force bank one
        if (!manual) begin
            s_d.follow2 = 1'b0;
        end else if (bank_sel != s_q.follow2 && !cmd_busy && motor_stopped) begin
            s_d.follow2 = bank_sel;
        end
        if (!ramp_en) begin
            // direct bank, no wait or ramp
            s_d.phase = PH_IDLE;
            s_d.on2 = want2;
            s_d.tgt2 = want2;
            // rest of bank switches regardless of motion
            s_d.coef = want2 ? s_q.b2 : s_q.b1;
        end else begin
            case (s_q.phase)
                PH_IDLE: begin
                    if (want2 != s_q.on2) begin
                        s_d.tgt2 = want2;
                        s_d.start = s_q.coef;
                        s_d.tick = 32'h0;
                        s_d.ms = 16'h0;
                        s_d.phase = PH_WAIT;
                    end else begin
                        s_d.coef = s_q.on2 ? s_q.b2 : s_q.b1;
                    end
                end
                PH_WAIT, PH_RAMP: begin
                    if (want2 != s_q.tgt2) begin
                        // restart opposite way from where we are
                        s_d.tgt2 = want2;
                        s_d.on2 = !want2;
                        s_d.start = s_q.coef;
                        s_d.tick = 32'h0;
                        s_d.ms = 16'h0;
                        s_d.phase = PH_WAIT;
                    end else if (s_q.phase == PH_WAIT && s_q.ms >= wlen) begin
                        s_d.phase = PH_RAMP;
                        s_d.tick = 32'h0;
                        s_d.ms = 16'h0;
                    end else if (s_q.phase == PH_RAMP && s_q.ms >= rlen) begin
                        s_d.coef = tgt_v;
                        s_d.on2 = s_q.tgt2;
                        s_d.phase = PH_IDLE;
                    end else begin
                        if (s_q.phase == PH_RAMP) s_d.coef = ramp_v;
                        if (s_q.tick == TICK_CYC - 32'h1) begin
                            s_d.tick = 32'h0;
                            s_d.ms = s_q.ms + 16'h1;
                        end else begin
                            s_d.tick = s_q.tick + 32'h1;
                        end
                    end
                end
                default: s_d.phase = PH_IDLE;
            endcase
        end
        // follow pair tracks its own bank flag
        s_d.coef[4] = s_d.follow2 ? s_q.b2[4] : s_q.b1[4];
        s_d.coef[5] = s_d.follow2 ? s_q.b2[5] : s_q.b1[5];
        s_d.mon = s_d.on2 ? `SGB_MON_BANK2 : `SGB_MON_BANK1;
        // read data comes from the post-write copy, so a write followed by a read is seen
        case (haddr[7:0])
            `SGB_OFS_CFG: rd = {16'h0, s_d.cfg};
            `SGB_OFS_WAIT_UP: rd = {16'h0, s_d.wait_up};
            `SGB_OFS_WAIT_DOWN: rd = {16'h0, s_d.wait_down};
            `SGB_OFS_RAMP_UP: rd = {16'h0, s_d.ramp_up};
            `SGB_OFS_RAMP_DOWN: rd = {16'h0, s_d.ramp_down};
            `SGB_OFS_STATUS: begin
                rd[1:0] = s_d.mon;
                rd[`SGB_STAT_WAIT_BIT] = (s_d.phase == PH_WAIT);
                rd[`SGB_STAT_RAMP_BIT] = (s_d.phase == PH_RAMP);
                rd[`SGB_STAT_FOLLOW_BIT] = s_d.follow2;
            end
            default: ;
        endcase
        for (int i = 0; i < 7; i++) begin
            if (haddr[7:0] == `SGB_OFS_BANK1 + 8'(i * 4)) rd = {16'h0, s_d.b1[i]};
            if (haddr[7:0] == `SGB_OFS_BANK2 + 8'(i * 4)) rd = {16'h0, s_d.b2[i]};
        end
        s_d.rdata = (acc && !hwrite) ? rd : 32'h0;
        s_d.dp_wr = acc && hwrite;
        s_d.dp_addr = haddr[7:0];
        s_d.rdy = 1'b1;
        s_d.resp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout = s_q.rdy;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign speed_gain = s_q.coef[0];
    assign speed_integral = s_q.coef[1];
    assign position_gain = s_q.coef[2];
    assign force_filter = s_q.coef[3];
    assign follow_gain = s_q.coef[4];
    assign follow_comp = s_q.coef[5];
    assign friction_gain = s_q.coef[6];
    assign active_bank_monitor = s_q.mon;
    // structure flag passes through, switching ignores it
    assign loop_structure_select = s_q.cfg[`SGB_LOOP_BIT];

    // ****************************************
    // checks
    // ****************************************
    manual_bank_a: assert property (@(posedge hclk) disable iff (!hresetn)
        manual |=> s_q.on2 == $past(bank_sel)) else $error("manual bank does not follow select input");
    auto_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !manual |=> follow_gain == $past(s_q.b1[4]) && follow_comp == $past(s_q.b1[5]))
        else $error("follow pair left bank one outside manual mode");
    follow_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        manual && (cmd_busy || !motor_stopped) |=> $stable(s_q.follow2))
        else $error("follow pair swapped while moving");
    other_swap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        manual |=> position_gain == ($past(bank_sel) ? $past(s_q.b2[2]) : $past(s_q.b1[2])))
        else $error("manual change did not swap position gain");
    fixed_bank_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_auto && !pos_ctrl |=> s_q.on2 == $past(fixed2) && s_q.phase == PH_IDLE)
        else $error("fixed bank wrong outside position control");
    cond_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ramp_en && s_q.phase == PH_IDLE && cond_a != s_q.on2 |=> s_q.phase == PH_WAIT && s_q.tgt2 == $past(cond_a))
        else $error("condition change did not start a wait");
    wait_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.phase == PH_WAIT |-> s_q.coef[3:0] == s_q.start[3:0] && s_q.coef[6] == s_q.start[6])
        else $error("coefficient moved during wait");
    ramp_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.phase == PH_RAMP |-> s_q.ms <= rlen) else $error("ramp overran its switching time");
    reverse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ramp_en && s_q.phase == PH_RAMP && want2 != s_q.tgt2
        |=> s_q.phase == PH_WAIT && s_q.start == $past(s_q.coef) && s_q.ms == 16'h0)
        else $error("reversal did not restart from current values");
    tuneless_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tuneless |=> !s_q.on2 && active_bank_monitor == `SGB_MON_BANK1)
        else $error("tuning-less did not force bank one");

endmodule : sgb_switch

// >>> verification/sgb_host_model.sv
`timescale 1ns/1ps

// ****************************************
// host controller and drive status model
// ****************************************
module sgb_host_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // wanted levels: select, position control, busy, stopped, four flags
    input wire logic [7:0] want,
    // lines toward the drive
    output logic bank_sel,
    output logic pos_ctrl,
    output logic cmd_busy,
    output logic motor_stopped,
    output logic [3:0] flags
);
    // select level picks the bank in manual mode
    // the host changes its lines only just after an edge, never between edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {bank_sel, pos_ctrl, cmd_busy, motor_stopped, flags} <= 8'h00;
        end else begin
            {bank_sel, pos_ctrl, cmd_busy, motor_stopped, flags} <= want;
        end
    end
endmodule : sgb_host_model

// >>> verification/sgb_switch_tb_top.sv
`timescale 1ns/1ps
`include "sgb_regs.svh"

// ****************************************
// testbench top
// ****************************************
module sgb_switch_tb_top;
    import sgb_pkg::*;
    localparam int TICK = 4;
    localparam int CEIL = 20000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] want = 8'h00;
    logic bank_sel;
    logic pos_ctrl;
    logic cmd_busy;
    logic motor_stopped;
    logic [3:0] flags;
    sgb_word_t co [7];
    logic [1:0] mon;
    logic loop_sel;
    sgb_word_t b1e [7] = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h01F4, 16'h03E8, 16'h0064};
    logic [3:0] tv [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h0, 4'h1};
    logic [3:0] fv [6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h3, 4'h0};
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;

    always #2.5 hclk = ~hclk;

    sgb_host_model host_u (.hclk(hclk), .hresetn(hresetn), .want(want), .bank_sel(bank_sel),
        .pos_ctrl(pos_ctrl), .cmd_busy(cmd_busy), .motor_stopped(motor_stopped), .flags(flags));

    // short tick keeps a millisecond at four cycles
    sgb_switch #(.TICK_CYC(TICK)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .bank_sel(bank_sel), .pos_ctrl(pos_ctrl),
        .cmd_busy(cmd_busy), .motor_stopped(motor_stopped), .pos_done(flags[3]), .pos_near(flags[2]),
        .filter_busy(flags[1]), .ref_pulse(flags[0]), .speed_gain(co[0]), .speed_integral(co[1]),
        .position_gain(co[2]), .force_filter(co[3]), .follow_gain(co[4]), .follow_comp(co[5]),
        .friction_gain(co[6]), .active_bank_monitor(mon), .loop_structure_select(loop_sel));

    // ****************************************
    // tasks
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    task automatic drive(input logic [7:0] w);
        @(posedge hclk);
        want <= w;
        step(5);
    endtask : drive

    task automatic chk_bank(input int b, input int fb);
        sgb_word_t e;
        for (int i = 0; i < 7; i++) begin
            e = ((((i == 4) || (i == 5)) ? fb : b) == 2) ? 16'h1000 + 16'(i) : b1e[i];
            chk("coefficient", {16'h0, co[i]}, {16'h0, e});
        end
        chk("monitor", {30'h0, mon}, 32'(b));
    endtask : chk_bank

    always @(posedge hclk) begin
        cyc++;
        if (cyc == CEIL) begin
            num_errors++;
            close_out();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        int n;
        step(5);
        hresetn <= 1'b1;
        chk_bank(1, 1);
        xfer(1'b0, `SGB_OFS_CFG, 32'h0);
        chk("cfg", rd, 32'h0);
        chk("response", {31'h0, hresp}, 32'h0);
        for (int i = 1; i < 5; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("time", rd, 32'h0);
        end
        xfer(1'b0, 8'h1C, 32'h0);
        chk("unmapped", rd, 32'h0);
        xfer(1'b1, `SGB_OFS_RAMP_DOWN, 32'hFFFF);
        xfer(1'b0, `SGB_OFS_RAMP_DOWN, 32'h0);
        chk("time max", rd, 32'hFFFF);
        xfer(1'b1, `SGB_OFS_RAMP_DOWN, 32'h0);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, `SGB_OFS_BANK2 + 8'(4 * i), 32'h1000 + 32'(i));
        end
        $display("test reset done");
        // manual: select, position control, busy, stopped, then flags
        drive(8'hD0);
        chk_bank(2, 2);
        drive(8'h50);
        chk_bank(1, 1);
        drive(8'hF0);
        chk_bank(2, 1);
        drive(8'hD0);
        chk_bank(2, 2);
        xfer(1'b0, `SGB_OFS_STATUS, 32'h0);
        chk("status follow", rd, 32'h102);
        drive(8'h40);
        chk_bank(1, 2);
        drive(8'h50);
        $display("test manual done");
        // automatic on positioning done, I-P loop structure; mode 1 never written
        xfer(1'b1, `SGB_OFS_WAIT_UP, 32'h2);
        xfer(1'b1, `SGB_OFS_RAMP_UP, 32'h4);
        // only codes 0 and 2 go into the mode digit
        xfer(1'b1, `SGB_OFS_CFG, 32'h0102);
        step(2);
        chk("loop", {31'h0, loop_sel}, 32'h1);
        @(posedge hclk);
        want <= 8'h58;
        step(6);
        chk("waiting", {16'h0, co[2]}, {16'h0, b1e[2]});
        xfer(1'b0, `SGB_OFS_STATUS, 32'h0);
        chk("status wait", rd, 32'h11);
        step(12);
        chk("mid ramp", {31'h0, ((co[2] > b1e[2]) && (co[2] < 16'h1002))}, 32'h1);
        n = 21;
        while (mon !== 2'h2 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        chk("switch span", {31'h0, (n >= 5 * TICK) && (n <= 9 * TICK)}, 32'h1);
        chk_bank(2, 1);
        drive(8'h50);
        chk_bank(1, 1);
        @(posedge hclk);
        want <= 8'h58;
        step(16);
        want <= 8'h50;
        step(10);
        chk_bank(1, 1);
        $display("test automatic done");
        xfer(1'b1, `SGB_OFS_WAIT_UP, 32'h0);
        xfer(1'b1, `SGB_OFS_RAMP_UP, 32'h0);
        for (int c = 0; c < 6; c++) begin
            drive({4'h5, fv[c]});
            xfer(1'b1, `SGB_OFS_CFG, 32'h2 | (32'(c) << 4));
            step(6);
            chk_bank(1, 1);
            drive({4'h5, tv[c]});
            chk_bank(2, 1);
            drive({4'h1, tv[c]});
            chk_bank((c % 2) + 1, 1);
            drive({4'h1, fv[c]});
            chk_bank((c % 2) + 1, 1);
        end
        $display("test conditions done");
        xfer(1'b1, `SGB_OFS_CFG, 32'h1002);
        drive(8'h58);
        chk_bank(1, 1);
        xfer(1'b0, `SGB_OFS_STATUS, 32'h0);
        chk("status", rd & 32'h3, 32'h1);
        xfer(1'b1, `SGB_OFS_CFG, 32'h0);
        drive(8'h50);
        xfer(1'b1, `SGB_OFS_BANK1, 32'h0123);
        b1e[0] = 16'h0123;
        step(2);
        chk_bank(1, 1);
        $display("test settings done");
        // reset in mid-run must bring back bank one with its reset values
        @(posedge hclk);
        hresetn <= 1'b0;
        step(2);
        hresetn <= 1'b1;
        b1e[0] = 16'h0190;
        chk_bank(1, 1);
        xfer(1'b0, `SGB_OFS_BANK1, 32'h0);
        chk("bank one reset", rd, 32'h0190);
        $display("test second reset done");
        close_out();
    end
endmodule : sgb_switch_tb_top
